// File: design/lbm_pkg.sv
/*
 * Package for the leaky-bucket activity monitor: register addresses,
 * reset values, field layout and timing counts.
 * Assumes a 125 MHz system clock and an 8-bit register port.
 */
`default_nettype none
package lbm_pkg;
    // Register addresses on the device register port
    localparam logic [7:0] LBM_ADDR_MAX_LEVEL = 8'h56;
    localparam logic [7:0] LBM_ADDR_LEAK_RATE = 8'h57;
    // Reset values
    localparam logic [7:0] LBM_RST_MAX_LEVEL = 8'h08;
    localparam logic [1:0] LBM_RST_LEAK_RATE = 2'h1;
    // Leak rate field position and width
    localparam int LBM_LEAK_LSB = 0;
    localparam int LBM_LEAK_W = 2;
    // Timing: monitoring cycle length
    localparam int LBM_CLK_HZ = 125000000;
    localparam int LBM_CYCLE_MS = 128;
    localparam int LBM_CYCLE_CLKS = (LBM_CLK_HZ / 1000) * LBM_CYCLE_MS;

    // Register write request carried as one bundle
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } lbm_wreq_t;
endpackage
`default_nettype wire

// File: design/lbm_leaky_bucket.sv
/*
 * Leaky-bucket accumulator for activity monitoring, configuration 1.
 * Assumes fault_i is a level from the activity detector on mclk_i
 * (same domain, no synchroniser); register writes arrive on a simple
 * synchronous write/read port in the same domain.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE1] 8-bit programmable maximum bucket level
// [RULE2] Accumulator saturates at programmed maximum
// [RULE3] Leak code selects 128/256/512/1024 ms
// [RULE4] Leak rate resets to code 01
// [RULE5] Leak needs 1/2/4/8 clean cycles
// [RULE6] 128 ms cycles; faulty cycle adds one
// [RULE7] Completed clean run subtracts one
// [RULE8] Count never underflows below zero
module lbm_leaky_bucket
    import lbm_pkg::*;
#(
    parameter int CYCLE_CLKS = LBM_CYCLE_CLKS  // Clocks per monitoring cycle
) (
    input wire logic mclk_i,              // System clock, 125 MHz
    input wire logic rst_n_i,             // Synchronous reset, active low
    input wire lbm_wreq_t wreq_i,         // Register write request
    input wire logic [7:0] rd_addr_i,     // Register read address
    input wire logic fault_i,             // Input failed or erratic (level)
    output logic [7:0] rd_data_o,         // Register read data, registered
    output logic [7:0] level_o,           // Accumulator level
    output logic cycle_end_o              // Pulse at each cycle end
);

    localparam int CW = $clog2(CYCLE_CLKS);

    logic [7:0] max_level_q;      // Bucket ceiling
    logic [1:0] leak_rate_q;      // Leak rate code
    logic [CW-1:0] tick_cnt_q;    // Clocks within current cycle
    logic cycle_end;              // Last clock of a cycle
    logic fault_seen_q;           // Any fault during current cycle
    logic [2:0] clean_cnt_q;      // Clean cycles since last leak or faulty cycle
    logic [7:0] acc_q;            // Accumulator
    logic [3:0] clean_need;       // Clean cycles per decrement
    logic leak_due;               // A clean run completes now

    // Clean cycles per decrement for a leak code
    function automatic logic [3:0] clean_len(input logic [1:0] code);
        clean_len = 4'h1 << code;  // [RULE3] [RULE5]
    endfunction

    assign cycle_end = (tick_cnt_q == CW'(CYCLE_CLKS - 1));
    assign clean_need = clean_len(leak_rate_q);
    // Compare with >= so that a leak code lowered in mid-run leaks at once
    // instead of letting the run counter climb past the new length
    assign leak_due = !(fault_seen_q || fault_i)
        && (({1'b0, clean_cnt_q} + 4'h1) >= clean_need);  // [RULE7]

    // Register writes
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            max_level_q <= LBM_RST_MAX_LEVEL;  // [RULE1]
            leak_rate_q <= LBM_RST_LEAK_RATE;  // [RULE4]
        end else if (wreq_i.wr) begin
            if (wreq_i.addr == LBM_ADDR_MAX_LEVEL) begin
                max_level_q <= wreq_i.data;  // [RULE1]
            end
            if (wreq_i.addr == LBM_ADDR_LEAK_RATE) begin
                leak_rate_q <= wreq_i.data[LBM_LEAK_LSB +: LBM_LEAK_W];  // [RULE3]
            end
        end
    end

    // Register reads; unused bits and unmapped addresses read zero
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_addr_i == LBM_ADDR_MAX_LEVEL) begin
            rd_data_o <= max_level_q;
        end else if (rd_addr_i == LBM_ADDR_LEAK_RATE) begin
            rd_data_o <= {6'h00, leak_rate_q};
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    // Free-running 128 ms cycle timer
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || cycle_end) begin
            tick_cnt_q <= '0;  // [RULE6]
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // Fault capture; a fault on the last clock still counts via fault_i
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || cycle_end) begin
            fault_seen_q <= 1'b0;
        end else if (fault_i) begin
            fault_seen_q <= 1'b1;  // [RULE6]
        end
    end

    // Clean-run counter; a faulty cycle restarts the run
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            clean_cnt_q <= 3'h0;
        end else if (cycle_end) begin
            if (fault_seen_q || fault_i || leak_due) begin
                clean_cnt_q <= 3'h0;  // [RULE7]
            end else begin
                clean_cnt_q <= clean_cnt_q + 3'h1;  // [RULE5]
            end
        end
    end

    // Accumulator: fill, leak, ceiling and floor
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            acc_q <= 8'h00;
        end else if (cycle_end) begin
            if (fault_seen_q || fault_i) begin
                // A lowered ceiling pulls the count down at once
                if (acc_q >= max_level_q) begin
                    acc_q <= max_level_q;  // [RULE2]
                end else begin
                    acc_q <= acc_q + 8'h01;  // [RULE6]
                end
            end else if (leak_due && acc_q != 8'h00) begin
                acc_q <= (acc_q > max_level_q) ? max_level_q : acc_q - 8'h01;  // [RULE7] [RULE8]
            end else if (acc_q > max_level_q) begin
                acc_q <= max_level_q;  // [RULE2]
            end
        end
    end

    // Output copies straight from flip-flops
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            level_o <= 8'h00;
            cycle_end_o <= 1'b0;
        end else begin
            level_o <= acc_q;
            cycle_end_o <= cycle_end;
        end
    end

    property p_fill;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end && fault_i && acc_q < max_level_q && !wreq_i.wr
            |=> acc_q == $past(acc_q) + 8'h01;
    endproperty
    a_fill: assert property (p_fill) else $error("fill missed"); // [RULE6]

    property p_ceiling;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end |=> acc_q <= $past(max_level_q);
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("above ceiling"); // [RULE2]

    property p_floor;
        @(posedge mclk_i) disable iff (!rst_n_i)
        acc_q == 8'h00 && !(cycle_end && fault_i) && !fault_seen_q |=> acc_q == 8'h00;
    endproperty
    a_floor: assert property (p_floor) else $error("underflow"); // [RULE8]

    property p_leak;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end && leak_due && acc_q != 8'h00 && acc_q <= max_level_q
            |=> acc_q == $past(acc_q) - 8'h01;
    endproperty
    a_leak: assert property (p_leak) else $error("leak missed"); // [RULE7]

    // After any cycle end the run stays shorter than the length that was due
    property p_run_len;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end |=> {1'b0, clean_cnt_q} < $past(clean_need);
    endproperty
    a_run_len: assert property (p_run_len) else $error("clean run too long"); // [RULE5]

    // Last clock of a cycle that saw no fault on any clock
    sequence s_clean_last;
        cycle_end && !fault_i && !fault_seen_q;
    endsequence

    // A clean cycle that does not finish the run lengthens it by one
    property p_run_step;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_clean_last ##0 !leak_due |=> clean_cnt_q == $past(clean_cnt_q) + 3'h1;
    endproperty
    a_run_step: assert property (p_run_step) else $error("clean run not counted"); // [RULE5]

    // A faulty cycle throws away the clean run so far
    property p_fault_restart;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end && (fault_i || fault_seen_q) |=> clean_cnt_q == 3'h0;
    endproperty
    a_fault_restart: assert property (p_fault_restart) else $error("run kept"); // [RULE7]

    property p_no_leak_early;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end && !leak_due && !fault_i && !fault_seen_q && acc_q <= max_level_q
            |=> acc_q == $past(acc_q);
    endproperty
    a_no_leak_early: assert property (p_no_leak_early) else $error("early leak"); // [RULE3]

    property p_reset_rate;
        @(posedge mclk_i) $rose(rst_n_i)
            |-> leak_rate_q == LBM_RST_LEAK_RATE && max_level_q == LBM_RST_MAX_LEVEL;
    endproperty
    a_reset_rate: assert property (p_reset_rate) else $error("bad reset values"); // [RULE4]

    property p_wr_max;
        @(posedge mclk_i) disable iff (!rst_n_i)
        wreq_i.wr && wreq_i.addr == LBM_ADDR_MAX_LEVEL |=> max_level_q == $past(wreq_i.data);
    endproperty
    a_wr_max: assert property (p_wr_max) else $error("size write lost"); // [RULE1]

    // Only the low field of a leak rate write is kept
    property p_wr_rate;
        @(posedge mclk_i) disable iff (!rst_n_i)
        wreq_i.wr && wreq_i.addr == LBM_ADDR_LEAK_RATE
            |=> leak_rate_q == $past(wreq_i.data[LBM_LEAK_LSB +: LBM_LEAK_W]);
    endproperty
    a_wr_rate: assert property (p_wr_rate) else $error("rate write lost"); // [RULE3]

    // Unused upper bits of the leak rate register read back as zero
    property p_rd_rate;
        @(posedge mclk_i) disable iff (!rst_n_i)
        rd_addr_i == LBM_ADDR_LEAK_RATE |=> rd_data_o == {6'h00, $past(leak_rate_q)};
    endproperty
    a_rd_rate: assert property (p_rd_rate) else $error("rate read wrong"); // [RULE3]

    // The pulse comes first, the new level one clock after it
    property p_out_copy;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cycle_end |=> cycle_end_o ##1 level_o == $past(acc_q);
    endproperty
    a_out_copy: assert property (p_out_copy) else $error("level not shown"); // [RULE6]

endmodule

`default_nettype wire

// File: bench/test_lbm_leaky_bucket.sv
/* Testbench for lbm_leaky_bucket: register port, fill, leak rates, clamping.
   Assumes the monitoring cycle is shortened to CY clocks and cycles start at reset. */
`timescale 1ns/1ps
`default_nettype none
module test_lbm_leaky_bucket;
    import lbm_pkg::*;
    localparam int CY = 8; // Short monitoring cycle keeps the run brief
    logic mclk_i = 1'b0; // System clock
    logic rst_n_i = 1'b0; // Reset, active low
    lbm_wreq_t wreq_i = '0; // Write bundle
    logic [7:0] rd_addr_i = 8'h00; // Read address
    logic fault_i = 1'b0; // Fault level from detector
    logic [7:0] rd_data_o, level_o; // Design outputs
    logic cycle_end_o; // Cycle end pulse
    int error_cnt = 0, num_checks = 0, tmo = 0, m_tm, m_run, m_n; // Counters and model state
    logic [7:0] m_acc, m_max; // Expected count and size limit
    logic [1:0] m_code; // Expected leak code
    logic m_f, m_l, m_end; // Fault seen, expected pulse, level check due
    always #4 mclk_i = ~mclk_i;
    lbm_leaky_bucket #(.CYCLE_CLKS(CY)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .wreq_i(wreq_i), .rd_addr_i(rd_addr_i), .fault_i(fault_i), .rd_data_o(rd_data_o),
        .level_o(level_o), .cycle_end_o(cycle_end_o));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Expected bucket: evaluated at each cycle's last clock, shown one edge later
    always @(posedge mclk_i) begin
        m_l <= rst_n_i && m_tm == CY - 1;
        m_end <= rst_n_i && m_l;
        if (!rst_n_i) begin
            m_acc <= 8'h00;
            m_max <= LBM_RST_MAX_LEVEL;
            m_code <= LBM_RST_LEAK_RATE;
            m_tm <= 0;
            m_run <= 0;
            m_f <= 1'b0;
        end else begin
            m_tm <= (m_tm == CY - 1) ? 0 : m_tm + 1;
            m_f <= (m_tm == CY - 1) ? 1'b0 : (m_f | fault_i);
            if (wreq_i.wr && wreq_i.addr == LBM_ADDR_MAX_LEVEL) m_max <= wreq_i.data;
            if (wreq_i.wr && wreq_i.addr == LBM_ADDR_LEAK_RATE) m_code <= wreq_i.data[1:0];
            if (m_tm == CY - 1) begin
                m_n = m_acc;
                m_run <= 0;
                // A faulty cycle also breaks the clean run
                if (m_f | fault_i) m_n = m_acc + 1;
                else if (m_run + 1 >= (1 << m_code)) m_n = (m_acc == 0) ? 0 : m_acc - 1;
                else m_run <= m_run + 1;
                m_acc <= (m_n > m_max) ? m_max : 8'(m_n);
            end
        end
    end
    // Per-cycle comparison of the pulse and the level, plus the hang guard
    always @(posedge mclk_i) begin
        #1;
        check("cycle_end_o", cycle_end_o, m_l);
        if (m_end) check("level_o", level_o, m_acc);
        tmo++;
        if (tmo == 4000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wreq_i <= '{wr: 1'b1, addr: a, data: d};
        @(posedge mclk_i);
        wreq_i <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_addr_i <= a;
        @(posedge mclk_i);
        #1;
        check("rd_data_o", rd_data_o, e);
    endtask
    // Waits for n cycle-end pulses, so later writes land far from the last clock
    task automatic cyc(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge mclk_i);
                #1;
                k++;
            end while (cycle_end_o !== 1'b1 && k < 2 * CY);
        end
    endtask
    task automatic t_regs();
        rd(LBM_ADDR_MAX_LEVEL, 8'h08);
        rd(LBM_ADDR_LEAK_RATE, 8'h01);
        wr(LBM_ADDR_LEAK_RATE, 8'hFE);
        rd(LBM_ADDR_LEAK_RATE, 8'h02);
        wr(8'h58, 8'h55);
        rd(8'h58, 8'h00);
        wr(LBM_ADDR_MAX_LEVEL, 8'hA5);
        rd(LBM_ADDR_MAX_LEVEL, 8'hA5);
    endtask
    task automatic t_fill();
        wr(LBM_ADDR_MAX_LEVEL, 8'h03);
        wr(LBM_ADDR_LEAK_RATE, 8'h00);
        fault_i <= 1'b1;
        cyc(6);
        check("level_o", level_o, 8'h03);
        @(posedge mclk_i);
        fault_i <= 1'b0;
        cyc(5);
        check("level_o", level_o, 8'h00);
    endtask
    // Size lowered below the count clamps it at the next cycle end
    task automatic t_lower();
        wr(LBM_ADDR_MAX_LEVEL, 8'h08);
        wr(LBM_ADDR_LEAK_RATE, 8'h03);
        fault_i <= 1'b1;
        cyc(5);
        @(posedge mclk_i);
        fault_i <= 1'b0;
        wr(LBM_ADDR_MAX_LEVEL, 8'h02);
        cyc(2);
        check("level_o", level_o, 8'h02);
    endtask
    task automatic t_codes();
        wr(LBM_ADDR_MAX_LEVEL, 8'h08);
        for (int c = 0; c < 4; c++) begin
            wr(LBM_ADDR_LEAK_RATE, 8'(c));
            fault_i <= 1'b1;
            cyc(2);
            @(posedge mclk_i);
            fault_i <= 1'b0;
            cyc(5 * (1 << c) + 2);
            check("level_o", level_o, 8'h00);
        end
    endtask
    // One-clock faults: first on a cycle's last clock, then in mid-cycle
    task automatic t_glitch();
        cyc(1);
        repeat (CY - 1) @(posedge mclk_i);
        fault_i <= 1'b1;
        @(posedge mclk_i);
        fault_i <= 1'b0;
        cyc(2);
        check("level_o", level_o, 8'h01);
        repeat (3) @(posedge mclk_i);
        fault_i <= 1'b1;
        @(posedge mclk_i);
        fault_i <= 1'b0;
        cyc(2);
        check("level_o", level_o, 8'h02);
    endtask
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_fill();
        t_lower();
        t_codes();
        t_glitch();
        give_verdict();
    end
endmodule
`default_nettype wire
